// [sds_pkg.sv]
package sds_pkg;
    localparam int CLK_HZ = 10_000_000;
    // frame processing busy interval, microseconds
    localparam int FRAME_BUSY_US = 1000;
    localparam int FRAME_BUSY_CYC = FRAME_BUSY_US * (CLK_HZ / 1_000_000);
    // initialization after reset release, milliseconds (longest)
    localparam int INIT_MS = 200;
    localparam int INIT_CYC = INIT_MS * (CLK_HZ / 1000);
    // frame layout: 8-bit command, 8-bit data
    localparam int FRAME_BITS = 16;
    localparam logic [7:0] CMD_ENTER_OPERATION_COMMAND = 8'h01;
    localparam logic [7:0] CMD_DEACTIVATE = 8'h02;
    localparam logic [7:0] CMD_SETTING = 8'h10;
    localparam logic [7:0] CMD_STATUS = 8'h20;
    // setting register bits (1 = serial source, 0 = pin source)
    localparam int SRC_EXCITE = 0;
    localparam int SRC_SMOOTH = 1;
    localparam int SRC_STOPCUR = 2;
    localparam int SRC_PULSE_MODE = 3;
    localparam int SRC_WIDTH = 8;
    localparam logic [SRC_WIDTH-1:0] SETTING_RESET = 8'h0f;
    localparam logic [1:0] SERIAL_VAL_RESET = 2'h3;
    localparam int STEP_WIDTH = 8;
    localparam logic [STEP_WIDTH-1:0] STEP_ZERO = 8'h00;
    typedef enum logic [1:0] {
        SDS_INIT, SDS_SETTING, SDS_SWITCH, SDS_OPERATION
    } sds_state_type;
endpackage : sds_pkg

// [sds_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module sds_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : sds_sync
`default_nettype wire

// [sds_sequencer.sv]
// Notes on behaviour
// (R1) The motor is never excited in the setting state, even with enable low.
// (R2) The host leaves at least 5 us before the first pulse after reversal.
// (R3) A chip-select fall starts frame processing; no serial shifting then.
// (R4) The host spaces serial frames at least 1 ms apart.
// (R5) During a state switch all commands but another transition are taken.
// (R6) Reset pin held low 10 ms; init within 200 ms, outputs open, no drive.
// (R7) Settings come from serial by default; only a serial write moves one.
// (R8) Ready goes low only with no alarm, reset high, operation, excitation.
// (R9) A reset-pin fall de-excites, zeroes step, clears alarm, resets state.
// (R10) Step pulses move one step in the mode and direction selected.
// (R11) Any alarm opens the fault output and cuts excitation at once.
// (R12) A busy interval from chip-select fall blocks shifting until done.
`timescale 1ns/1ps
`default_nettype none
module sds_sequencer
    import sds_pkg::*;
#(
    parameter int BUSY_CYC = FRAME_BUSY_CYC,
    parameter int INIT_CYCLES = INIT_CYC
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // control pins (asynchronous)
    input wire logic reset_pin_n_in,
    input wire logic enable_n_in,
    input wire logic smooth_pin_in,
    input wire logic stop_current_pin_in,
    input wire logic pulse_mode_pin_in,
    input wire logic fault_detect_in,
    // pulse pins: step/forward, direction/reverse
    input wire logic forward_pulse_in,
    input wire logic reverse_pulse_in,
    // serial link
    input wire logic spi_ss_n_in,
    input wire logic spi_sck_in,
    input wire logic spi_mosi_in,
    output logic spi_miso_out,
    output logic spi_miso_oe_out,
    // indications, open collector: oe high pulls low
    output logic fault_output_oe_out,
    output logic pulse_accept_ready_oe_out,
    output logic step_zero_oe_out,
    // motor drive
    output logic excite_out,
    output logic smooth_out,
    output logic stop_current_out,
    output logic [STEP_WIDTH-1:0] step_position_out
);
    import sds_pkg::*;

    localparam int BCW = $clog2(BUSY_CYC + 1);
    localparam int ICW = $clog2(INIT_CYCLES + 1);

    // ========================================
    // synchronisers
    logic [9:0] raw_w;
    logic [9:0] syn_w;
    assign raw_w = {reset_pin_n_in, enable_n_in, smooth_pin_in,
                    stop_current_pin_in, pulse_mode_pin_in, fault_detect_in,
                    forward_pulse_in, reverse_pulse_in, spi_ss_n_in,
                    spi_sck_in};
    sds_sync #(.WIDTH(10)) u_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .async_in(raw_w),
        .sync_out(syn_w)
    );
    logic mosi_m_q, mosi_q;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mosi_m_q <= 1'b0;
            mosi_q <= 1'b0;
        end else begin
            mosi_m_q <= spi_mosi_in;
            mosi_q <= mosi_m_q;
        end
    end
    logic rst_pin_n, en_n, smooth_pin, stop_pin, mode_pin, fault_in;
    logic fwd, rev, ss_n, sck;
    assign {rst_pin_n, en_n, smooth_pin, stop_pin, mode_pin, fault_in,
            fwd, rev, ss_n, sck} = syn_w;

    // ========================================
    // edge detection
    logic rst_pin_q, fwd_q, rev_q, ss_q, sck_q;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_pin_q <= 1'b1;
            fwd_q <= 1'b0;
            rev_q <= 1'b0;
            ss_q <= 1'b1;
            sck_q <= 1'b0;
        end else begin
            rst_pin_q <= rst_pin_n;
            fwd_q <= fwd;
            rev_q <= rev;
            ss_q <= ss_n;
            sck_q <= sck;
        end
    end
    logic rst_fall, ss_fall, sck_rise, sck_fall, fwd_rise, rev_rise;
    assign rst_fall = rst_pin_q && !rst_pin_n;
    assign ss_fall = ss_q && !ss_n;
    assign sck_rise = !sck_q && sck;
    assign sck_fall = sck_q && !sck;
    assign fwd_rise = !fwd_q && fwd;
    assign rev_rise = !rev_q && rev;
    // whole-device restart: pin fall or pin held low
    logic soft_rst;
    assign soft_rst = rst_fall || !rst_pin_n; // R9

    // ========================================
    // frame processing busy interval
    logic [BCW-1:0] busy_q;
    logic busy;
    assign busy = busy_q != '0;
    logic frame_done;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy_q <= '0;
        end else if (soft_rst) begin
            busy_q <= '0;
        end else if (ss_fall && !busy) begin
            busy_q <= BCW'(BUSY_CYC); // R3 R12
        end else if (busy) begin
            busy_q <= busy_q - 1'b1;
        end
    end
    assign frame_done = busy_q == BCW'(1);

    // ========================================
    // serial shifter: active outside processing, framed by chip select low
    logic [FRAME_BITS-1:0] rx_q;
    logic [FRAME_BITS-1:0] tx_q;
    logic [FRAME_BITS-1:0] status_w;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_q <= '0;
        end else if (soft_rst) begin
            rx_q <= '0;
        end else if (!busy && !ss_n && sck_rise) begin
            rx_q <= {rx_q[FRAME_BITS-2:0], mosi_q}; // R3
        end
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_q <= '0;
        end else if (soft_rst) begin
            tx_q <= '0;
        end else if (frame_done) begin
            tx_q <= status_w;
        end else if (!busy && !ss_n && sck_fall) begin
            tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0}; // R12
        end
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            spi_miso_out <= 1'b0;
            spi_miso_oe_out <= 1'b0;
        end else begin
            spi_miso_out <= tx_q[FRAME_BITS-1];
            spi_miso_oe_out <= !ss_n && !busy && rst_pin_n; // R3
        end
    end
    // frame is decoded once, at end of processing
    logic [7:0] cmd_w, dat_w;
    assign cmd_w = rx_q[FRAME_BITS-1 -: 8];
    assign dat_w = rx_q[7:0];

    // ========================================
    // internal state machine
    sds_state_type state_q;
    logic [ICW-1:0] init_q;
    logic do_act, do_deact;
    assign do_act = frame_done && cmd_w == CMD_ENTER_OPERATION_COMMAND;
    assign do_deact = frame_done && cmd_w == CMD_DEACTIVATE;
    logic alarm_q;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= SDS_INIT;
            init_q <= ICW'(INIT_CYCLES);
        end else if (soft_rst) begin
            state_q <= SDS_INIT; // R9
            init_q <= ICW'(INIT_CYCLES);
        end else begin
            case (state_q)
                SDS_INIT: begin
                    if (init_q == '0) begin
                        state_q <= SDS_SETTING; // R6
                    end else begin
                        init_q <= init_q - 1'b1;
                    end
                end
                SDS_SETTING: begin
                    if (do_act && !alarm_q) begin
                        state_q <= SDS_SWITCH;
                    end
                end
                // transition commands ignored here, others still taken
                SDS_SWITCH: begin
                    state_q <= SDS_OPERATION; // R5
                end
                SDS_OPERATION: begin
                    if (do_deact) begin
                        state_q <= SDS_SETTING;
                    end
                end
                default: state_q <= SDS_INIT;
            endcase
        end
    end

    // ========================================
    // setting sources, serial by default
    logic [SRC_WIDTH-1:0] src_q;
    logic [1:0] serial_val_q; // smooth, stop-current values
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            src_q <= SETTING_RESET; // R7
            serial_val_q <= SERIAL_VAL_RESET;
        end else if (soft_rst) begin
            src_q <= SETTING_RESET; // R9
            serial_val_q <= SERIAL_VAL_RESET;
        end else if (frame_done && cmd_w == CMD_SETTING) begin
            src_q <= dat_w; // R7 R5
        end else if (frame_done && cmd_w == CMD_STATUS) begin
            serial_val_q <= dat_w[1:0];
        end
    end

    // ========================================
    // alarm: sticky until reset pin
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            alarm_q <= 1'b0;
        end else if (soft_rst) begin
            alarm_q <= 1'b0; // R9
        end else if (fault_in) begin
            alarm_q <= 1'b1;
        end
    end

    // ========================================
    // excitation and readiness
    logic excite_d, ready_d, operating;
    assign operating = state_q == SDS_OPERATION;
    always_comb begin
        excite_d = operating && !alarm_q && !fault_in && rst_pin_n; // R1 R11
        if (!src_q[SRC_EXCITE]) begin
            excite_d = excite_d && !en_n;
        end
        ready_d = excite_d; // R8
    end
    logic ready_q;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            excite_out <= 1'b0;
            ready_q <= 1'b0;
            fault_output_oe_out <= 1'b0;
            pulse_accept_ready_oe_out <= 1'b0;
            smooth_out <= 1'b1;
            stop_current_out <= 1'b1;
        end else begin
            excite_out <= excite_d && !soft_rst; // R1 R9 R11
            ready_q <= ready_d && !soft_rst;
            pulse_accept_ready_oe_out <= ready_d && !soft_rst; // R8
            // pulled low when healthy, open on alarm or init
            fault_output_oe_out <= !alarm_q && !fault_in &&
                state_q != SDS_INIT && !soft_rst; // R11 R6
            smooth_out <= src_q[SRC_SMOOTH] ? serial_val_q[1] : smooth_pin;
            stop_current_out <= src_q[SRC_STOPCUR] ? serial_val_q[0]
                                                   : stop_pin;
        end
    end

    // ========================================
    // step position
    logic dual_mode, step_fwd, step_rev;
    assign dual_mode = src_q[SRC_PULSE_MODE] ? 1'b0 : mode_pin;
    assign step_fwd = dual_mode ? fwd_rise : (fwd_rise && rev); // R10
    assign step_rev = dual_mode ? rev_rise : (fwd_rise && !rev); // R10
    logic [STEP_WIDTH-1:0] step_q;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            step_q <= STEP_ZERO;
        end else if (soft_rst || state_q == SDS_SWITCH) begin
            step_q <= STEP_ZERO; // R9
        end else if (ready_q && step_fwd && !step_rev) begin
            step_q <= step_q + 1'b1; // R8 R10
        end else if (ready_q && step_rev && !step_fwd) begin
            step_q <= step_q - 1'b1;
        end
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            step_position_out <= STEP_ZERO;
            step_zero_oe_out <= 1'b0;
        end else begin
            step_position_out <= step_q;
            step_zero_oe_out <= step_q == STEP_ZERO && excite_d;
        end
    end

    assign status_w = {6'h00, state_q, 3'h0, dual_mode, ready_q,
                       excite_out, alarm_q, busy};
endmodule : sds_sequencer
`default_nettype wire

// [sds_seq_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// port checks for the sequencer
module sds_seq_assertions
    import sds_pkg::*;
#(
    parameter int BUSY_CYC = FRAME_BUSY_CYC,
    parameter int INIT_CYCLES = INIT_CYC
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic reset_pin_n_in,
    input wire logic fault_detect_in,
    input wire logic spi_ss_n_in,
    input wire logic spi_miso_oe_out,
    input wire logic fault_output_oe_out,
    input wire logic pulse_accept_ready_oe_out,
    input wire logic excite_out,
    input wire logic [STEP_WIDTH-1:0] step_position_out
);
    localparam int INIT_MAX = INIT_CYCLES + 20;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    property p_ready_gate;
        pulse_accept_ready_oe_out |-> (excite_out || $past(excite_out))
            && (fault_output_oe_out || $past(fault_output_oe_out));
    endproperty
    a_ready_gate: assert property (p_ready_gate)
        else $error("ready without excitation or with alarm");
    property p_fault_cut;
        fault_detect_in [*6] |-> !excite_out && !fault_output_oe_out
            && !pulse_accept_ready_oe_out;
    endproperty
    a_fault_cut: assert property (p_fault_cut)
        else $error("alarm did not cut excitation");
    property p_rst_pin;
        !reset_pin_n_in [*6] |-> !excite_out && !fault_output_oe_out
            && step_position_out == STEP_ZERO;
    endproperty
    a_rst_pin: assert property (p_rst_pin)
        else $error("reset pin did not restart");
    property p_rst_open;
        $rose(reset_pin_n_in) |-> (!fault_output_oe_out && !excite_out) [*8];
    endproperty
    a_rst_open: assert property (p_rst_open)
        else $error("outputs not open during init");
    property p_init_done;
        $rose(reset_pin_n_in) && !fault_detect_in
            |-> ##[INIT_CYCLES:INIT_MAX] fault_output_oe_out;
    endproperty
    a_init_done: assert property (p_init_done)
        else $error("init did not finish in time");
    property p_step_gate;
        $changed(step_position_out) && step_position_out != STEP_ZERO
            |-> $past(pulse_accept_ready_oe_out);
    endproperty
    a_step_gate: assert property (p_step_gate)
        else $error("step moved while not ready");
    property p_step_one;
        $changed(step_position_out) && step_position_out != STEP_ZERO
            |-> step_position_out == $past(step_position_out) + 8'h01
            || step_position_out == $past(step_position_out) - 8'h01;
    endproperty
    a_step_one: assert property (p_step_one)
        else $error("step moved by more than one");
    property p_miso_quiet;
        spi_ss_n_in [*6] |-> !spi_miso_oe_out;
    endproperty
    a_miso_quiet: assert property (p_miso_quiet)
        else $error("serial output driven while deselected");
endmodule : sds_seq_assertions
bind sds_sequencer sds_seq_assertions #(
    .BUSY_CYC(BUSY_CYC), .INIT_CYCLES(INIT_CYCLES)
) u_sds_seq_assertions (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .reset_pin_n_in(reset_pin_n_in), .fault_detect_in(fault_detect_in),
    .spi_ss_n_in(spi_ss_n_in), .spi_miso_oe_out(spi_miso_oe_out),
    .fault_output_oe_out(fault_output_oe_out),
    .pulse_accept_ready_oe_out(pulse_accept_ready_oe_out),
    .excite_out(excite_out), .step_position_out(step_position_out)
);
`default_nettype wire

// [sds_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// host side of the serial link, mode 0, msb first
module sds_host_model
    import sds_pkg::*;
#(
    parameter int GAP_NS = 4000
) (
    output logic ss_n_out,
    output logic sck_out,
    output logic mosi_out,
    input wire logic miso_in,
    output logic [FRAME_BITS-1:0] got_out
);
    initial begin
        ss_n_out = 1'b1;
        sck_out = 1'b0;
        mosi_out = 1'b1;
        got_out = '0;
    end
    // select stays low; a high pulse then a fall commits the frame
    task automatic send(input logic [FRAME_BITS-1:0] f);
        #33;
        ss_n_out = 1'b0;
        #(GAP_NS);
        for (int i = FRAME_BITS - 1; i >= 0; i--) begin
            mosi_out = f[i];
            #400 sck_out = 1'b1;
            got_out = {got_out[FRAME_BITS-2:0], miso_in};
            #400 sck_out = 1'b0;
        end
        mosi_out = 1'b1;
        #400 ss_n_out = 1'b1;
        #800 ss_n_out = 1'b0;
    endtask : send
endmodule : sds_host_model
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
    num_checks++; \
    if ((a) !== (e)) begin \
        miscompares++; \
        $display("BAD t=%0t got %h exp %h", $time, (a), (e)); \
    end \
end
// ============================================================
// bench for the sequencer
module tb;
    import sds_pkg::*;
    localparam int BUSY = 20;
    localparam int INIT = 10;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic reset_pin_n_in = 1'b1;
    logic enable_n_in = 1'b0;
    logic smooth_pin_in = 1'b0;
    logic stop_current_pin_in = 1'b0;
    logic pulse_mode_pin_in = 1'b0;
    logic fault_detect_in = 1'b0;
    logic forward_pulse_in = 1'b0;
    logic reverse_pulse_in = 1'b0;
    wire logic ss_n;
    wire logic sck;
    wire logic mosi;
    logic miso, miso_oe, fault_oe, ready_oe, zero_oe, excite, smooth, stopc;
    logic [STEP_WIDTH-1:0] step;
    logic [FRAME_BITS-1:0] got;
    // pull-up on the serial output line while released
    wire logic miso_line = miso_oe ? miso : 1'b1;
    int miscompares = 0;
    int num_checks = 0;
    // frame, then excite, ready, smooth, stop current
    logic [19:0] rows [8] = '{20'h20000, 20'h20033, 20'h0100f,
        20'h1009c, 20'h0100c, 20'h02000, 20'h100f3, 20'h0100f};
    // mode pin, direction pin, forward pin, expected step
    logic [10:0] moves [7] = '{11'h301, 11'h100, 11'h1ff, 11'h500,
        11'h4ff, 11'h500, 11'h501};
    always #50 clk_in = ~clk_in;
    sds_sequencer #(.BUSY_CYC(BUSY), .INIT_CYCLES(INIT)) u_sds_sequencer (
        .clk_in(clk_in), .resetn_in(resetn_in),
        .reset_pin_n_in(reset_pin_n_in), .enable_n_in(enable_n_in),
        .smooth_pin_in(smooth_pin_in),
        .stop_current_pin_in(stop_current_pin_in),
        .pulse_mode_pin_in(pulse_mode_pin_in),
        .fault_detect_in(fault_detect_in),
        .forward_pulse_in(forward_pulse_in),
        .reverse_pulse_in(reverse_pulse_in),
        .spi_ss_n_in(ss_n), .spi_sck_in(sck), .spi_mosi_in(mosi),
        .spi_miso_out(miso), .spi_miso_oe_out(miso_oe),
        .fault_output_oe_out(fault_oe),
        .pulse_accept_ready_oe_out(ready_oe),
        .step_zero_oe_out(zero_oe), .excite_out(excite),
        .smooth_out(smooth), .stop_current_out(stopc),
        .step_position_out(step));
    sds_host_model u_sds_host_model (
        .ss_n_out(ss_n), .sck_out(sck), .mosi_out(mosi),
        .miso_in(miso_line), .got_out(got));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc
    task automatic frame(input logic [15:0] f);
        u_sds_host_model.send(f);
        cyc(BUSY + 12);
    endtask : frame
    task automatic step_pulse_in(input logic on_fwd);
        cyc(60);
        if (on_fwd) forward_pulse_in = 1'b1;
        else reverse_pulse_in = 1'b1;
        cyc(10);
        if (on_fwd) forward_pulse_in = 1'b0;
        else reverse_pulse_in = 1'b0;
        cyc(10);
    endtask : step_pulse_in
    task automatic wait_up;
        for (int i = 0; i < 60; i++) begin
            if (fault_oe !== 1'b1) cyc(1);
        end
        if (fault_oe !== 1'b1) begin
            miscompares++;
            close_out();
        end
    endtask : wait_up
    task automatic close_out;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    initial begin
        #3_000_000;
        miscompares++;
        close_out();
    end
    initial begin
        cyc(1);
        `CHK({fault_oe, ready_oe, excite, smooth, stopc, step}, 13'h0300)
        cyc(1);
        resetn_in = 1'b1;
        cyc(3);
        `CHK(fault_oe, 1'b0)
        wait_up();
        `CHK(fault_oe, 1'b1)
        $display("test reset done");
        foreach (rows[i]) begin
            frame(rows[i][19:4]);
            `CHK({excite, ready_oe, smooth, stopc}, rows[i][3:0])
            if (i == 4) `CHK(got, 16'h030d)
            $display("test row %0d done", i);
        end
        frame(16'h1007);
        `CHK({zero_oe, step}, {1'b1, STEP_ZERO})
        foreach (moves[i]) begin
            pulse_mode_pin_in = moves[i][10];
            reverse_pulse_in = moves[i][9];
            step_pulse_in(moves[i][8]);
            `CHK({zero_oe, step}, {~|moves[i][7:0], moves[i][7:0]})
        end
        $display("test steps done");
        frame(16'h1000);
        `CHK({excite, smooth, stopc}, 3'b100)
        enable_n_in = 1'b1;
        cyc(6);
        `CHK({excite, ready_oe, zero_oe}, 3'b000)
        enable_n_in = 1'b0;
        cyc(6);
        `CHK({excite, ready_oe}, 2'b11)
        $display("test enable pin done");
        fault_detect_in = 1'b1;
        cyc(8);
        `CHK({fault_oe, ready_oe, excite}, 3'b000)
        reset_pin_n_in = 1'b0;
        cyc(30);
        fault_detect_in = 1'b0;
        `CHK({excite, step}, 9'h000)
        reset_pin_n_in = 1'b1;
        cyc(5);
        `CHK(fault_oe, 1'b0)
        wait_up();
        `CHK({fault_oe, smooth, stopc, excite}, 4'he)
        frame(16'h0100);
        `CHK({excite, ready_oe, step}, 10'h300)
        `CHK(got, 16'h0000)
        $display("test fault and reset done");
        close_out();
    end
endmodule : tb
`default_nettype wire
